// file: rtl/buck_cfg_pkg.sv
// Constants shared by the regulator configuration register bank.
// Assumes byte-wide registers reached through a serial bus front end.
package buck_cfg_pkg;

  // ****************************************************************
  // Register offsets.
  // ****************************************************************
  localparam logic [7:0] OFS_OUTPUT_VOLTAGE_TARGET = 8'h04;
  localparam logic [7:0] OFS_CURRENT_LIMIT_SELECT = 8'h05;
  localparam logic [7:0] OFS_OUTPUT_DISCHARGE_CONTROL = 8'h06;
  localparam logic [7:0] OFS_SETTINGS_REVERT_TRIGGER = 8'h07;

  // ****************************************************************
  // Reset values and field layout.
  // ****************************************************************
  localparam logic [6:0] RST_VOUT_CODE = 7'h7b;
  localparam logic [3:0] RST_LIMIT_CODE = 4'hf;
  localparam logic RST_DISCHARGE_EN = 1'b0;
  localparam logic [1:0] RST_DISCHARGE_SEL = 2'h0;
  localparam logic [7:0] RST_REVERT_TRIGGER = 8'h00;
  localparam int DISCHARGE_EN_BIT = 2;
  localparam logic [7:0] REVERT_KEY = 8'h60;

  // ****************************************************************
  // Code ranges and scaling.
  // ****************************************************************
  localparam logic [6:0] VOUT_CODE_MIN = 7'h0f;
  localparam logic [6:0] VOUT_CODE_MAX = 7'h7b;
  localparam logic [11:0] VOUT_BASE_MV = 12'h258;
  localparam logic [11:0] VOUT_STEP_MV = 12'h019;
  localparam logic [11:0] LIMIT_BASE_MA = 12'h212;
  localparam logic [11:0] LIMIT_STEP_MA = 12'h06c;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Discharge strength selections.
  typedef enum logic [1:0] {
    DIS_OPEN = 2'h0,
    DIS_200_OHM = 2'h1,
    DIS_100_OHM = 2'h2,
    DIS_50_OHM = 2'h3
  } discharge_strength_t;

  // True for a target code that may be used for regulation.
  function automatic logic vout_code_valid(input logic [6:0] code);
    vout_code_valid = (code >= VOUT_CODE_MIN) && (code <= VOUT_CODE_MAX);
  endfunction : vout_code_valid

endpackage : buck_cfg_pkg

// file: rtl/msb_first_shifter.sv
// Byte shifter that moves bits most significant first in and out.
// Assumes strobes are one-cycle pulses synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module msb_first_shifter
  import buck_cfg_pkg::*;
(
  input wire logic clk,             // Core clock.
  input wire logic srst,            // Synchronous reset, active high.
  input wire logic restart,         // Drops a partial byte.
  input wire logic shift_en,        // Shift one bit.
  input wire logic ser_in,          // Serial bit entering at the bottom.
  input wire logic load_en,         // Parallel load.
  input wire logic [7:0] par_in,    // Parallel load value.
  output logic [7:0] par_out,       // Shift register contents.
  output logic ser_out,             // Bit currently presented, the top bit.
  output logic byte_done            // Pulse after the eighth shifted bit.
);

  // ****************************************************************
  // Shift register and bit counter.
  // ****************************************************************
  logic [7:0] shift_reg;
  logic [3:0] count_reg;
  logic done_reg;

  // Bits enter at the bottom and leave from the top.
  always_ff @(posedge clk) begin
    if (srst) begin
      shift_reg <= 8'h00;
    end else if (load_en) begin
      shift_reg <= par_in;
    end else if (shift_en) begin
      shift_reg <= {shift_reg[6:0], ser_in};
    end
  end

  // Counts bits so that a byte boundary is flagged.
  always_ff @(posedge clk) begin
    if (srst || restart || load_en) begin
      count_reg <= 4'h0;
      done_reg <= 1'b0;
    end else if (shift_en) begin
      count_reg <= (count_reg == BITS_PER_BYTE - 4'h1) ? 4'h0 : count_reg + 4'h1;
      done_reg <= (count_reg == BITS_PER_BYTE - 4'h1);
    end else begin
      done_reg <= 1'b0;
    end
  end

  assign par_out = shift_reg;
  assign ser_out = shift_reg[7];
  assign byte_done = done_reg;

endmodule : msb_first_shifter
`default_nettype wire

// file: rtl/buck_regulator_config_regs.sv
// Configuration register bank of a step-down regulator.
// Assumes a serial protocol engine delivers frame starts and bit strobes.
`timescale 1ns/10ps
`default_nettype none
module buck_regulator_config_regs
  import buck_cfg_pkg::*;
(
  input wire logic CORE_CLK,        // Core clock, 250 MHz.
  input wire logic SRST,            // Synchronous reset, active high.
  input wire logic FRAME_START,     // Pulse: next received byte is an address.
  input wire logic RX_BIT_VALID,    // Pulse: RX_BIT carries a received bit.
  input wire logic RX_BIT,          // Received serial bit.
  input wire logic TX_LOAD,         // Pulse: fetch the byte at the pointer.
  input wire logic TX_BIT_SHIFT,    // Pulse: advance to the next bit to send.
  input wire logic REG_ENABLE,      // Regulation enable bit.
  output logic TX_BIT,              // Serial bit to send.
  output logic [6:0] VOUT_CODE,     // Applied target code.
  output logic [11:0] VOUT_MV,      // Applied target in millivolts.
  output logic VOUT_CODE_RESERVED,  // Stored target code is reserved.
  output logic [3:0] CURRENT_LIMIT_CODE, // Current limit code.
  output logic [11:0] CURRENT_LIMIT_MA,  // Current limit in milliamps.
  output logic REGULATE_ON,         // Regulator running.
  output logic DISCHARGE_ON,        // Output discharge active.
  output logic [1:0] DISCHARGE_SEL  // Discharge strength.
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic [7:0] rx_byte;
  logic rx_done;
  logic expect_addr_reg;
  logic [7:0] ptr_reg;
  logic [6:0] output_voltage_target_reg;
  logic [3:0] current_limit_select_reg;
  logic discharge_en_reg;
  logic [1:0] discharge_sel_reg;
  logic wr_strobe;
  logic soft_revert;
  logic settings_reset;
  logic [7:0] rd_data;
  logic en_prev_reg;
  logic discharge_reg;
  logic [6:0] applied_code_reg;
  logic [11:0] vout_mv_reg;
  logic [11:0] limit_ma_reg;
  logic reserved_reg;
  logic regulate_reg;

  // ****************************************************************
  // Serial byte assembly.
  // ****************************************************************

  // Receive side collects bytes from the engine.
  msb_first_shifter rx_shift (
    .clk(CORE_CLK),
    .srst(SRST),
    .restart(FRAME_START),
    .shift_en(RX_BIT_VALID),
    .ser_in(RX_BIT),
    .load_en(1'b0),
    .par_in(8'h00),
    .par_out(rx_byte),
    .ser_out(),
    .byte_done(rx_done)
  );

  // Send side presents read data one bit at a time.
  msb_first_shifter tx_shift (
    .clk(CORE_CLK),
    .srst(SRST),
    .restart(1'b0),
    .shift_en(TX_BIT_SHIFT),
    .ser_in(1'b0),
    .load_en(TX_LOAD),
    .par_in(rd_data),
    .par_out(),
    .ser_out(TX_BIT),
    .byte_done()
  );

  // ****************************************************************
  // Address pointer.
  // ****************************************************************

  // First byte of a frame sets the pointer; each access advances it.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      expect_addr_reg <= 1'b1;
      ptr_reg <= 8'h00;
    end else if (FRAME_START) begin
      expect_addr_reg <= 1'b1;
    end else if (rx_done) begin
      expect_addr_reg <= 1'b0;
      ptr_reg <= expect_addr_reg ? rx_byte : ptr_reg + 8'h01;
    end else if (TX_LOAD) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  assign wr_strobe = rx_done && !expect_addr_reg && !FRAME_START;
  assign soft_revert = wr_strobe && (ptr_reg == OFS_SETTINGS_REVERT_TRIGGER) && (rx_byte == REVERT_KEY);
  assign settings_reset = SRST || soft_revert;

  // ****************************************************************
  // Settings registers.
  // ****************************************************************

  // Target code register, seven bits wide.
  always_ff @(posedge CORE_CLK) begin
    if (settings_reset) begin
      output_voltage_target_reg <= RST_VOUT_CODE;
    end else if (wr_strobe && ptr_reg == OFS_OUTPUT_VOLTAGE_TARGET) begin
      output_voltage_target_reg <= rx_byte[6:0];
    end
  end

  // Current limit register, four bits wide.
  always_ff @(posedge CORE_CLK) begin
    if (settings_reset) begin
      current_limit_select_reg <= RST_LIMIT_CODE;
    end else if (wr_strobe && ptr_reg == OFS_CURRENT_LIMIT_SELECT) begin
      current_limit_select_reg <= rx_byte[3:0];
    end
  end

  // Discharge control register.
  always_ff @(posedge CORE_CLK) begin
    if (settings_reset) begin
      discharge_en_reg <= RST_DISCHARGE_EN;
      discharge_sel_reg <= RST_DISCHARGE_SEL;
    end else if (wr_strobe && ptr_reg == OFS_OUTPUT_DISCHARGE_CONTROL) begin
      discharge_en_reg <= rx_byte[DISCHARGE_EN_BIT];
      discharge_sel_reg <= rx_byte[1:0];
    end
  end

  // Read multiplexer; the trigger and unmapped offsets read zero.
  always_comb begin
    rd_data = 8'h00;
    case (ptr_reg)
      OFS_OUTPUT_VOLTAGE_TARGET: rd_data = {1'b0, output_voltage_target_reg};
      OFS_CURRENT_LIMIT_SELECT: rd_data = {4'h0, current_limit_select_reg};
      OFS_OUTPUT_DISCHARGE_CONTROL: rd_data = {5'h00, discharge_en_reg, discharge_sel_reg};
      OFS_SETTINGS_REVERT_TRIGGER: rd_data = RST_REVERT_TRIGGER;
      default: rd_data = 8'h00;
    endcase
  end

  // ****************************************************************
  // Regulation outputs.
  // ****************************************************************

  // Reserved codes are never applied; the last valid target stays.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      applied_code_reg <= RST_VOUT_CODE;
      vout_mv_reg <= VOUT_BASE_MV + VOUT_STEP_MV * 12'(RST_VOUT_CODE - VOUT_CODE_MIN);
      reserved_reg <= 1'b0;
    end else begin
      reserved_reg <= !vout_code_valid(output_voltage_target_reg);
      if (vout_code_valid(output_voltage_target_reg)) begin
        applied_code_reg <= output_voltage_target_reg;
        vout_mv_reg <= VOUT_BASE_MV + VOUT_STEP_MV * 12'(output_voltage_target_reg - VOUT_CODE_MIN);
      end
    end
  end

  // Current limit threshold in milliamps.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      limit_ma_reg <= LIMIT_BASE_MA + LIMIT_STEP_MA * 12'(RST_LIMIT_CODE);
    end else begin
      limit_ma_reg <= LIMIT_BASE_MA + LIMIT_STEP_MA * 12'(current_limit_select_reg);
    end
  end

  // Enable tracking and the discharge that follows a shutdown.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      en_prev_reg <= 1'b0;
      regulate_reg <= 1'b0;
      discharge_reg <= 1'b0;
    end else begin
      en_prev_reg <= REG_ENABLE;
      regulate_reg <= REG_ENABLE;
      if (!discharge_en_reg || REG_ENABLE) begin
        discharge_reg <= 1'b0;
      end else if (en_prev_reg) begin
        discharge_reg <= 1'b1;
      end
    end
  end

  assign VOUT_CODE = applied_code_reg;
  assign VOUT_MV = vout_mv_reg;
  assign VOUT_CODE_RESERVED = reserved_reg;
  assign CURRENT_LIMIT_CODE = current_limit_select_reg;
  assign CURRENT_LIMIT_MA = limit_ma_reg;
  assign REGULATE_ON = regulate_reg;
  assign DISCHARGE_ON = discharge_reg;
  assign DISCHARGE_SEL = discharge_sel_reg;

  // ****************************************************************
  // Checks.
  // ****************************************************************

  // Applied code is always inside the valid range.
  AST_APPLIED_VALID: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (VOUT_CODE >= 7'h0f) && (VOUT_CODE <= 7'h7b))
    else $error("Applied target code is reserved.");

  // Millivolt output follows a valid stored target code one cycle later, in step with the applied code.
  AST_VOUT_SCALE: assert property (@(posedge CORE_CLK) disable iff (SRST)
    vout_code_valid(output_voltage_target_reg) |=> VOUT_MV == 12'd600 + 12'd25 * 12'($past(output_voltage_target_reg) - 7'h0f))
    else $error("Target millivolts do not match code.");

  // A reserved high code leaves the applied target untouched.
  AST_RESERVED_HOLD: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (output_voltage_target_reg > 7'h7b) |=> $stable(VOUT_CODE) && VOUT_CODE_RESERVED)
    else $error("Reserved code changed the target.");

  // Current limit scaling.
  AST_LIMIT_SCALE: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (current_limit_select_reg == 4'h8) |=> CURRENT_LIMIT_MA == 12'd1394)
    else $error("Current limit scaling wrong.");

  // A key write restores defaults on the next edge.
  AST_REVERT: assert property (@(posedge CORE_CLK) disable iff (SRST)
    soft_revert |=> output_voltage_target_reg == 7'h7b && current_limit_select_reg == 4'hf
      && !discharge_en_reg && discharge_sel_reg == 2'h0)
    else $error("Settings not restored after key write.");

  // Any other trigger value keeps the settings.
  AST_NO_REVERT: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_strobe && ptr_reg == 8'h07 && rx_byte != 8'h60 |=> $stable(current_limit_select_reg)
      && $stable(output_voltage_target_reg))
    else $error("Non-key write changed settings.");

  // Trigger offset reads zero.
  AST_TRIGGER_READ: assert property (@(posedge CORE_CLK) disable iff (SRST)
    TX_LOAD && ptr_reg == 8'h07 |=> tx_shift.shift_reg == 8'h00)
    else $error("Trigger register returned data.");

  // Upper bits of the limit register leave the send shifter as zero.
  AST_UNUSED_ZERO: assert property (@(posedge CORE_CLK) disable iff (SRST)
    TX_LOAD && (ptr_reg == 8'h05) |=> tx_shift.shift_reg[7:4] == 4'h0)
    else $error("Unused bits read nonzero.");

  // Enable falling with discharge on starts discharge at the next edge; a level left from reset is no fall.
  AST_DISCHARGE_START: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !$past(SRST) && $fell(REG_ENABLE) && discharge_en_reg |=> DISCHARGE_ON)
    else $error("Discharge did not start.");

  // Discharge is off from the cycle after its enable bit is seen clear.
  AST_DISCHARGE_OFF: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !discharge_en_reg |=> !DISCHARGE_ON)
    else $error("Discharge active while disabled.");

  // The first bit sent is the top bit of the loaded byte.
  AST_MSB_FIRST: assert property (@(posedge CORE_CLK) disable iff (SRST)
    TX_LOAD |=> TX_BIT == $past(rd_data[7]))
    else $error("Send order not MSB first.");

endmodule : buck_regulator_config_regs
`default_nettype wire

// file: dv/serial_host_model.sv
// Bit-level host model that writes and reads the configuration bank.
// Assumes the caller enters every task just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  input wire logic clk,           // Core clock.
  input wire logic tx_bit,        // Bit sent back by the bank.
  output logic frame_start,       // Transaction start pulse.
  output logic rx_bit_valid,      // Bit strobe towards the bank.
  output logic rx_bit,            // Bit towards the bank.
  output logic tx_load,           // Fetch pulse for a read byte.
  output logic tx_bit_shift       // Advance pulse for read bits.
);
  // ****************************************************************
  // Bus cycle tasks.
  // ****************************************************************
  // All strobes start low so nothing is taken during reset.
  initial begin
    frame_start = 1'b0;
    rx_bit_valid = 1'b0;
    rx_bit = 1'b0;
    tx_load = 1'b0;
    tx_bit_shift = 1'b0;
  end

  // Moves to just after the next rising edge.
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  // Opens a transaction; the next byte becomes the pointer.
  task automatic start_frame();
    frame_start = 1'b1;
    tick();
    frame_start = 1'b0;
  endtask : start_frame

  // Sends one byte top bit first and leaves the strobe up for a following byte.
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      rx_bit_valid = 1'b1;
      rx_bit = b[i];
      tick();
    end
  endtask : send_byte

  // Drops the bit strobe; the idle line then flips so a stale bit is never mistaken.
  task automatic release_bits();
    rx_bit_valid = 1'b0;
    rx_bit = ~rx_bit;
  endtask : release_bits

  // Writes one byte at an offset and waits for the applied outputs to settle.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    start_frame();
    send_byte(addr);
    send_byte(data);
    release_bits();
    repeat (4) tick();
  endtask : write_reg

  // Points at an offset, fetches the byte and collects it top bit first.
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    start_frame();
    send_byte(addr);
    release_bits();
    repeat (2) tick();
    tx_load = 1'b1;
    tick();
    tx_load = 1'b0;
    data[7] = tx_bit;
    for (int i = 6; i >= 0; i--) begin
      tx_bit_shift = 1'b1;
      tick();
      data[i] = tx_bit;
    end
    tx_bit_shift = 1'b0;
  endtask : read_reg
endmodule : serial_host_model
`default_nettype wire

// file: dv/testbench.sv
// Self-checking testbench of the regulator configuration bank.
// Assumes the host model drives every bus input of the bank.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import buck_cfg_pkg::*;
  logic core_clk, srst, reg_enable, frame_start, rx_bit_valid, rx_bit, tx_load, tx_bit_shift, tx_bit;
  logic [6:0] vout_code;
  logic [11:0] vout_mv, limit_ma;
  logic [3:0] limit_code;
  logic [1:0] discharge_sel;
  logic vout_code_reserved, regulate_on, discharge_on;
  logic [7:0] rd;
  int mismatches = 0;
  int n_tests = 0;

  buck_regulator_config_regs i_dut (.CORE_CLK(core_clk), .SRST(srst), .FRAME_START(frame_start),
    .RX_BIT_VALID(rx_bit_valid), .RX_BIT(rx_bit), .TX_LOAD(tx_load), .TX_BIT_SHIFT(tx_bit_shift),
    .REG_ENABLE(reg_enable), .TX_BIT(tx_bit), .VOUT_CODE(vout_code), .VOUT_MV(vout_mv),
    .VOUT_CODE_RESERVED(vout_code_reserved), .CURRENT_LIMIT_CODE(limit_code), .CURRENT_LIMIT_MA(limit_ma),
    .REGULATE_ON(regulate_on), .DISCHARGE_ON(discharge_on), .DISCHARGE_SEL(discharge_sel));
  serial_host_model i_host (.clk(core_clk), .tx_bit(tx_bit), .frame_start(frame_start),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .tx_load(tx_load), .tx_bit_shift(tx_bit_shift));

  // ****************************************************************
  // Shared helpers.
  // ****************************************************************
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // Waits a bounded time for the discharge output to reach a level.
  task automatic wait_discharge(input logic lvl);
    int n;
    n = 0;
    while (discharge_on !== lvl && n < 8) begin
      i_host.tick();
      n++;
    end
    chk("discharge_on", 12'(lvl), 12'(discharge_on));
  endtask : wait_discharge

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  // Power-on contents at the outputs and through the bus.
  task automatic t_reset();
    chk("vout_code", 12'h07b, 12'(vout_code));
    chk("vout_mv", 12'd3300, vout_mv);
    chk("limit_ma", 12'd2150, limit_ma);
    chk("discharge_sel", 12'h000, 12'(discharge_sel));
    for (int a = 4; a < 8; a++) begin
      i_host.read_reg(8'(a), rd);
      chk("reset readback", (a == 4) ? 12'h07b : (a == 5) ? 12'h00f : 12'h000, 12'(rd));
    end
  endtask : t_reset

  // Valid, boundary and reserved target codes; the last valid code stays applied.
  task automatic t_vout();
    logic [7:0] codes [7] = '{8'h0f, 8'h4f, 8'h7b, 8'h10, 8'h0e, 8'h7c, 8'hff};
    logic [6:0] applied;
    logic res;
    applied = 7'h7b;
    foreach (codes[i]) begin
      i_host.write_reg(OFS_OUTPUT_VOLTAGE_TARGET, codes[i]);
      res = (codes[i][6:0] < 7'h0f) || (codes[i][6:0] > 7'h7b);
      if (!res) applied = codes[i][6:0];
      chk("vout_reserved", 12'(res), 12'(vout_code_reserved));
      chk("vout_code", 12'(applied), 12'(vout_code));
      chk("vout_mv", 12'd600 + 12'd25 * (12'(applied) - 12'h00f), vout_mv);
      i_host.read_reg(OFS_OUTPUT_VOLTAGE_TARGET, rd);
      chk("vout readback", 12'(codes[i] & 8'h7f), 12'(rd));
    end
  endtask : t_vout

  // Listed limit codes and a write that touches the unused upper bits.
  task automatic t_limit();
    logic [7:0] codes [5] = '{8'h00, 8'h04, 8'h08, 8'h0f, 8'hf3};
    foreach (codes[i]) begin
      i_host.write_reg(OFS_CURRENT_LIMIT_SELECT, codes[i]);
      chk("limit_code", 12'(codes[i][3:0]), 12'(limit_code));
      chk("limit_ma", 12'd530 + 12'd108 * 12'(codes[i][3:0]), limit_ma);
      i_host.read_reg(OFS_CURRENT_LIMIT_SELECT, rd);
      chk("limit readback", 12'(codes[i] & 8'h0f), 12'(rd));
    end
  endtask : t_limit

  // Every strength, then discharge on an enable fall with the bit set and clear.
  task automatic t_discharge();
    for (int s = 0; s < 4; s++) begin
      i_host.write_reg(OFS_OUTPUT_DISCHARGE_CONTROL, 8'hf8 | 8'(s));
      chk("discharge_sel", 12'(s), 12'(discharge_sel));
      i_host.read_reg(OFS_OUTPUT_DISCHARGE_CONTROL, rd);
      chk("discharge readback", 12'(s), 12'(rd));
    end
    i_host.write_reg(OFS_OUTPUT_DISCHARGE_CONTROL, 8'h07);
    reg_enable = 1'b1;
    repeat (3) i_host.tick();
    chk("regulate_on", 12'h001, 12'(regulate_on));
    chk("discharge_on", 12'h000, 12'(discharge_on));
    reg_enable = 1'b0;
    wait_discharge(1'b1);
    chk("regulate_on", 12'h000, 12'(regulate_on));
    reg_enable = 1'b1;
    wait_discharge(1'b0);
    i_host.write_reg(OFS_OUTPUT_DISCHARGE_CONTROL, 8'h03);
    reg_enable = 1'b0;
    repeat (4) i_host.tick();
    chk("discharge_on", 12'h000, 12'(discharge_on));
  endtask : t_discharge

  // Burst write, wrong key ignored, trigger and unmapped reads, then the revert key.
  task automatic t_revert();
    i_host.start_frame();
    i_host.send_byte(OFS_OUTPUT_VOLTAGE_TARGET);
    i_host.send_byte(8'h20);
    i_host.send_byte(8'h02);
    i_host.send_byte(8'h05);
    i_host.release_bits();
    repeat (4) i_host.tick();
    i_host.write_reg(OFS_SETTINGS_REVERT_TRIGGER, 8'h61);
    chk("vout_code", 12'h020, 12'(vout_code));
    chk("limit_code", 12'h002, 12'(limit_code));
    i_host.read_reg(OFS_OUTPUT_DISCHARGE_CONTROL, rd);
    chk("discharge readback", 12'h005, 12'(rd));
    i_host.read_reg(OFS_SETTINGS_REVERT_TRIGGER, rd);
    chk("trigger readback", 12'h000, 12'(rd));
    i_host.read_reg(8'h08, rd);
    chk("unmapped readback", 12'h000, 12'(rd));
    i_host.write_reg(OFS_SETTINGS_REVERT_TRIGGER, 8'h60);
    chk("vout_mv", 12'd3300, vout_mv);
    chk("limit_ma", 12'd2150, limit_ma);
    chk("discharge_sel", 12'h000, 12'(discharge_sel));
    i_host.read_reg(OFS_OUTPUT_DISCHARGE_CONTROL, rd);
    chk("discharge readback", 12'h000, 12'(rd));
  endtask : t_revert

  // ****************************************************************
  // Clock, reset and main sequence.
  // ****************************************************************
  // A 250 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Cuts a hang short.
  initial begin
    repeat (50000) @(posedge core_clk);
    mismatches++;
    wrap_up();
  end

  // Holds reset for eight cycles, then runs every scenario.
  initial begin
    srst = 1'b1;
    reg_enable = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    srst = 1'b0;
    i_host.tick();
    t_reset();
    t_vout();
    t_limit();
    t_discharge();
    t_revert();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
